// ===== tsq_core.sv
/*
  trigger sequencer data and queue registers with a small step engine that
  executes add, copy, literal, jump-while-counter and timer wait steps.
  assumes: single clk, word-indexed register port with read data one cycle
  after the read strobe; software loads registers before setting run.
*/
// Our own choices: the placing of the registers and the address-and-strobe port.
// How it works
// - timer 1 limit only used by the start-timer1-and-wait step
// - while enable and run are both set, software writes are ignored except to the control enable, run and visibility bits
// - with step delay on, each step lasts step-delay limit plus three clocks
// - counter 0 limit is the loop count of jump-while-counter0
// - counter 1 limit is the loop count of jump-while-counter1
// - copy step moves the hold value into the selected target
// - add step adds the adjust value into the selected target
// - literal control step writes the literal to adc channel select
// - five-bit queue pointer, upper bits read as zero
// - eight queue registers, step 2x low byte, 2x+1 high byte
// - queue contents are never cleared by any reset
// - add options 0-5 and copy options 8-13 pick c0,c1,t0,t1,sd,literal
// - visibility bit makes limit reads return live counter values
// - run bit starts sequential execution, clearing it stops
`default_nettype none
`include "tsq_map.svh"
module tsq_core (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic [15:0] adc_channel_select,
  output logic running
);
  tsq_pkg::tsq_word_t timer0_limit_q, timer1_limit_q, step_delay_limit_q;
  tsq_pkg::tsq_word_t loop_counter0_limit_q, loop_counter1_limit_q;
  tsq_pkg::tsq_word_t copy_source_value_q, add_source_value_q;
  tsq_pkg::tsq_word_t adc_channel_literal_q, adc_channel_select_q;
  tsq_pkg::tsq_word_t loop_count0_q, loop_count1_q, rdata_q;
  logic [4:0] active_step_pointer_q;
  logic sequencer_enable_bit_q, sequencer_run_bit_q, running_q;
  logic limit_read_visibility_q, delay_on_q;
  logic [15:0] queue_q [`TSQ_QUEUE_REGS];
  tsq_pkg::tsq_state_e state_q;
  logic [7:0] cmd_q;
  logic locked, sw_wr, wait_done, t_start;
  logic t0_run, t1_run, sd_run, t0_match, t1_match, sd_match;
  tsq_pkg::tsq_word_t t0_count, t1_count, sd_count;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    hit = (a == off);
  endfunction : hit

  // add or copy into one of the six targets
  function automatic tsq_pkg::tsq_word_t upd(input tsq_pkg::tsq_word_t cur,
                                             input logic [7:0] cmd,
                                             input tsq_pkg::tsq_target_e t,
                                             input tsq_pkg::tsq_word_t hold,
                                             input tsq_pkg::tsq_word_t adj);
    upd = cur;
    if (cmd[7:4] == 4'h1 && cmd[2:0] == 3'(t) && cmd[3:1] != 3'h7) begin
      upd = cmd[3] ? hold : 16'(cur + adj);
    end
  endfunction : upd

  assign locked = sequencer_enable_bit_q && sequencer_run_bit_q;
  assign sw_wr = reg_wr && !locked;
  assign running = running_q;

  // control bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sequencer_enable_bit_q <= 1'b0;
      sequencer_run_bit_q <= 1'b0;
      limit_read_visibility_q <= 1'b0;
      running_q <= 1'b0;
    end else if (reg_wr && hit(reg_addr, `TSQ_OFF_CTRL)) begin
      // control stays writable so software can stop the engine
      sequencer_enable_bit_q <= reg_wdata[`TSQ_CTRL_ENABLE_BIT];
      sequencer_run_bit_q <= reg_wdata[`TSQ_CTRL_RUN_BIT];
      limit_read_visibility_q <= reg_wdata[`TSQ_CTRL_VIS_BIT];
      running_q <= reg_wdata[`TSQ_CTRL_ENABLE_BIT] && reg_wdata[`TSQ_CTRL_RUN_BIT];
    end
  end

  // step engine
  assign t_start = (state_q == tsq_pkg::TSQ_EXEC);
  assign t0_run = (state_q == tsq_pkg::TSQ_WAIT) && cmd_q == 8'h08;
  assign t1_run = (state_q == tsq_pkg::TSQ_WAIT) && cmd_q == 8'h09;
  assign sd_run = (state_q == tsq_pkg::TSQ_WAIT);
  assign wait_done = (!delay_on_q || sd_match)
    && (cmd_q != 8'h08 || t0_match) && (cmd_q != 8'h09 || t1_match);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= tsq_pkg::TSQ_FETCH;
      cmd_q <= 8'h00;
    end else if (!locked) begin
      state_q <= tsq_pkg::TSQ_FETCH;
    end else begin
      unique case (state_q)
        tsq_pkg::TSQ_FETCH: begin
          cmd_q <= active_step_pointer_q[0] ?
            queue_q[active_step_pointer_q[3:1]][15:8] :
            queue_q[active_step_pointer_q[3:1]][7:0];
          state_q <= tsq_pkg::TSQ_EXEC;
        end
        tsq_pkg::TSQ_EXEC: begin
          state_q <= tsq_pkg::TSQ_WAIT;
        end
        tsq_pkg::TSQ_WAIT: begin
          if (wait_done) begin
            state_q <= tsq_pkg::TSQ_FETCH;
          end
        end
      endcase
    end
  end

  tsq_counter u_t0 (.clk(clk), .rst_b(rst_b), .start(t_start), .run(t0_run),
    .limit(timer0_limit_q), .match(t0_match), .count(t0_count));
  tsq_counter u_t1 (.clk(clk), .rst_b(rst_b), .start(t_start), .run(t1_run),
    .limit(timer1_limit_q), .match(t1_match), .count(t1_count));
  tsq_counter u_sd (.clk(clk), .rst_b(rst_b), .start(t_start), .run(sd_run),
    .limit(step_delay_limit_q), .match(sd_match), .count(sd_count));

  // step delay enable and pointer / loop counters
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      delay_on_q <= 1'b0;
    end else if (sw_wr && hit(reg_addr, `TSQ_OFF_CTRL)) begin
      delay_on_q <= reg_wdata[`TSQ_CTRL_DELAY_ON_BIT];
    end else if (t_start && cmd_q == 8'h02) begin
      delay_on_q <= 1'b0;
    end else if (t_start && cmd_q == 8'h06) begin
      delay_on_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      active_step_pointer_q <= 5'h00;
      loop_count0_q <= 16'h0000;
      loop_count1_q <= 16'h0000;
    end else if (sw_wr && hit(reg_addr, `TSQ_OFF_ACTIVE_STEP_POINTER)) begin
      active_step_pointer_q <= reg_wdata[4:0];
    end else if (locked && state_q == tsq_pkg::TSQ_WAIT && wait_done) begin
      unique casez (cmd_q[7:5])
        3'b101: active_step_pointer_q <= cmd_q[4:0];
        3'b110: begin
          if (loop_count0_q == loop_counter0_limit_q) begin
            loop_count0_q <= 16'h0000;
            active_step_pointer_q <= 5'(active_step_pointer_q + 5'h01);
          end else begin
            loop_count0_q <= 16'(loop_count0_q + 16'h0001);
            active_step_pointer_q <= cmd_q[4:0];
          end
        end
        3'b111: begin
          if (loop_count1_q == loop_counter1_limit_q) begin
            loop_count1_q <= 16'h0000;
            active_step_pointer_q <= 5'(active_step_pointer_q + 5'h01);
          end else begin
            loop_count1_q <= 16'(loop_count1_q + 16'h0001);
            active_step_pointer_q <= cmd_q[4:0];
          end
        end
        default: active_step_pointer_q <= 5'(active_step_pointer_q + 5'h01);
      endcase
    end
  end

  // limit, hold, adjust and literal registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer0_limit_q <= `TSQ_RESET_VALUE;
      timer1_limit_q <= `TSQ_RESET_VALUE;
      step_delay_limit_q <= `TSQ_RESET_VALUE;
      loop_counter0_limit_q <= `TSQ_RESET_VALUE;
      loop_counter1_limit_q <= `TSQ_RESET_VALUE;
      copy_source_value_q <= `TSQ_RESET_VALUE;
      add_source_value_q <= `TSQ_RESET_VALUE;
      adc_channel_literal_q <= `TSQ_RESET_VALUE;
    end else if (sw_wr) begin
      if (hit(reg_addr, `TSQ_OFF_TIMER0_LIMIT)) timer0_limit_q <= reg_wdata;
      if (hit(reg_addr, `TSQ_OFF_TIMER1_LIMIT)) timer1_limit_q <= reg_wdata;
      if (hit(reg_addr, `TSQ_OFF_STEP_DELAY_LIMIT)) step_delay_limit_q <= reg_wdata;
      if (hit(reg_addr, `TSQ_OFF_LOOP_COUNTER0_LIMIT)) loop_counter0_limit_q <= reg_wdata;
      if (hit(reg_addr, `TSQ_OFF_LOOP_COUNTER1_LIMIT)) loop_counter1_limit_q <= reg_wdata;
      if (hit(reg_addr, `TSQ_OFF_COPY_SOURCE_VALUE)) copy_source_value_q <= reg_wdata;
      if (hit(reg_addr, `TSQ_OFF_ADD_SOURCE_VALUE)) add_source_value_q <= reg_wdata;
      if (hit(reg_addr, `TSQ_OFF_ADC_CHANNEL_LITERAL)) adc_channel_literal_q <= reg_wdata;
    end else if (t_start) begin
      loop_counter0_limit_q <= upd(loop_counter0_limit_q, cmd_q, tsq_pkg::TSQ_TGT_C0,
        copy_source_value_q, add_source_value_q);
      loop_counter1_limit_q <= upd(loop_counter1_limit_q, cmd_q, tsq_pkg::TSQ_TGT_C1,
        copy_source_value_q, add_source_value_q);
      timer0_limit_q <= upd(timer0_limit_q, cmd_q, tsq_pkg::TSQ_TGT_T0,
        copy_source_value_q, add_source_value_q);
      timer1_limit_q <= upd(timer1_limit_q, cmd_q, tsq_pkg::TSQ_TGT_T1,
        copy_source_value_q, add_source_value_q);
      step_delay_limit_q <= upd(step_delay_limit_q, cmd_q, tsq_pkg::TSQ_TGT_SD,
        copy_source_value_q, add_source_value_q);
      adc_channel_literal_q <= upd(adc_channel_literal_q, cmd_q, tsq_pkg::TSQ_TGT_LIT,
        copy_source_value_q, add_source_value_q);
    end
  end

  // adc channel select driven by the control step
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      adc_channel_select_q <= 16'h0000;
    end else if (t_start) begin
      unique casez (cmd_q)
        8'h0c: adc_channel_select_q <= loop_count0_q;
        8'h0d: adc_channel_select_q <= loop_count1_q;
        8'h0e: adc_channel_select_q <= adc_channel_literal_q;
        8'b001?_????: adc_channel_select_q <= {11'h000, cmd_q[4:0]};
        default: adc_channel_select_q <= adc_channel_select_q;
      endcase
    end
  end
  assign adc_channel_select = adc_channel_select_q;

  // queue storage: no reset, contents survive every reset
  generate
    for (genvar i = 0; i < `TSQ_QUEUE_REGS; i++) begin : g_queue
      always_ff @(posedge clk) begin
        if (sw_wr && hit(reg_addr, 5'(`TSQ_OFF_QUEUE_BASE + i))) begin
          queue_q[i] <= reg_wdata;
        end
      end
    end
  endgenerate

  // read port, data valid one cycle after the strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 16'h0000;
    end else if (reg_rd) begin
      rdata_q <= 16'h0000;
      if (reg_addr[4:3] == 2'b10) begin
        rdata_q <= queue_q[reg_addr[2:0]];
      end else begin
        unique case (reg_addr)
          `TSQ_OFF_CTRL: rdata_q <= {sequencer_enable_bit_q, 6'h00,
            limit_read_visibility_q, sequencer_run_bit_q, 6'h00, delay_on_q};
          `TSQ_OFF_TIMER0_LIMIT:
            rdata_q <= limit_read_visibility_q ? t0_count : timer0_limit_q;
          `TSQ_OFF_TIMER1_LIMIT:
            rdata_q <= limit_read_visibility_q ? t1_count : timer1_limit_q;
          `TSQ_OFF_STEP_DELAY_LIMIT:
            rdata_q <= limit_read_visibility_q ? sd_count : step_delay_limit_q;
          `TSQ_OFF_LOOP_COUNTER0_LIMIT:
            rdata_q <= limit_read_visibility_q ? loop_count0_q : loop_counter0_limit_q;
          `TSQ_OFF_LOOP_COUNTER1_LIMIT:
            rdata_q <= limit_read_visibility_q ? loop_count1_q : loop_counter1_limit_q;
          `TSQ_OFF_COPY_SOURCE_VALUE: rdata_q <= copy_source_value_q;
          `TSQ_OFF_ADD_SOURCE_VALUE: rdata_q <= add_source_value_q;
          `TSQ_OFF_ADC_CHANNEL_LITERAL: rdata_q <= adc_channel_literal_q;
          `TSQ_OFF_ACTIVE_STEP_POINTER:
            rdata_q <= {11'h000, active_step_pointer_q};
          `TSQ_OFF_ADC_CHANNEL_SELECT: rdata_q <= adc_channel_select_q;
          default: rdata_q <= 16'h0000;
        endcase
      end
    end
  end
  assign reg_rdata = rdata_q;
endmodule : tsq_core
`default_nettype wire

// ===== tsq_core_chk.sv
/*
  concurrent checks on the tsq_core register port and outputs.
  assumes: bound to tsq_core; one clk, rst_b asynchronous and active low.
*/
`default_nettype none
module tsq_core_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [15:0] adc_channel_select,
  input wire logic running
);
  logic [15:0] hold_q;
  logic [15:0] adj_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // shadows of registers that only software writes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      hold_q <= 16'h0000;
    else if (reg_wr && !running && reg_addr == 5'h06)
      hold_q <= reg_wdata;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      adj_q <= 16'h0000;
    else if (reg_wr && !running && reg_addr == 5'h07)
      adj_q <= reg_wdata;
  end
  sequence rd_at(logic [4:0] a);
    reg_rd && reg_addr == a;
  endsequence
  sequence ctl_wr_then_idle;
    reg_wr && reg_addr == 5'h00 ##1 !reg_wr;
  endsequence
  hold_lock_a: assert property (rd_at(5'h06) |=> reg_rdata == $past(hold_q))
    else $error("hold readback differs from last unlocked write");
  adj_lock_a: assert property (rd_at(5'h07) |=> reg_rdata == $past(adj_q))
    else $error("adjust readback differs from last unlocked write");
  ptr_upper_a: assert property (rd_at(5'h09) |=> reg_rdata[15:5] == 11'h000)
    else $error("pointer upper bits not zero");
  unmapped_zero_a: assert property (
    reg_rd && ((reg_addr > 5'h0a && reg_addr < 5'h10) || reg_addr > 5'h17)
    |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  run_ctrl_a: assert property (ctl_wr_then_idle |=> running ==
    ($past(reg_wdata[15], 2) && $past(reg_wdata[7], 2)))
    else $error("running does not follow enable and run bits");
  run_hold_a: assert property (!(reg_wr && reg_addr == 5'h00) [*2] |=> $stable(running))
    else $error("running changed without control write");
  adc_idle_a: assert property (!running [*3] |=> $stable(adc_channel_select))
    else $error("channel select changed while stopped");
  adc_spacing_a: assert property ($changed(adc_channel_select)
    |=> $stable(adc_channel_select) [*2])
    else $error("channel select changed within one step");
  reset_clear_a: assert property ($rose(rst_b) |-> !running && adc_channel_select == 16'h0000)
    else $error("outputs not cleared by reset");
endmodule : tsq_core_chk
bind tsq_core tsq_core_chk i_tsq_core_chk (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .adc_channel_select(adc_channel_select), .running(running));
`default_nettype wire

// ===== tsq_core_tb.sv
/*
  self-checking bench for tsq_core: register port, lock, step engine.
  assumes: tsq_core_chk is bound from its own file.
*/
`default_nettype none
module tsq_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic [15:0] adc_channel_select;
  logic running;
  logic [15:0] v;
  int fails = 0;
  int check_count = 0;
  int seed = 49;
  int mdl[32];
  int tg[6] = '{4, 5, 1, 2, 3, 8};
  int n;
  int t0;
  tsq_core i_tsq_core (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .adc_channel_select(adc_channel_select), .running(running));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic report_and_stop;
    if (fails == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd_cmp(input logic [4:0] a, input logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    cmp(reg_rdata, e);
    @(posedge clk);
  endtask : rd_cmp
  task automatic chk(input logic [4:0] a);
    rd_cmp(a, 16'(mdl[a]));
  endtask : chk
  task automatic chk_all(input int top);
    for (int a = 1; a < top; a++) begin
      if (a < 10 || a > 15)
        chk(5'(a));
    end
  endtask : chk_all
  task automatic chk_run(input logic e);
    @(negedge clk);
    cmp({15'h0000, running}, {15'h0000, e});
    @(posedge clk);
  endtask : chk_run
  // load steps 0 to 3, start, then try locked writes
  task automatic run(input logic [15:0] q0, input logic [15:0] q1, input logic [15:0] ctl);
    wr(5'h09, 16'h0000);
    wr(5'h10, q0);
    wr(5'h11, q1);
    mdl[16] = q0;
    mdl[17] = q1;
    wr(5'h00, ctl);
    chk_run(1'b1);
    wr(5'h06, 16'(mdl[6]) ^ 16'hffff);
    wr(5'h10, ~q0);
  endtask : run
  task automatic stop(input int cyc);
    repeat (cyc) @(posedge clk);
    wr(5'h00, 16'h0000);
    chk_run(1'b0);
  endtask : stop
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    chk_all(10);
    chk(5'h0b);
    wr(5'h1f, 16'hffff);
    chk(5'h1f);
    for (int a = 1; a < 24; a++) begin
      if (a < 10 || a > 15) begin
        mdl[a] = $random(seed) & 32'hffff;
        wr(5'(a), 16'(mdl[a]));
      end
    end
    mdl[9] = mdl[9] & 32'h1f;
    chk_all(24);
    // live counters have not moved since reset, limits are random
    wr(5'h00, 16'h0100);
    rd_cmp(5'h00, 16'h0100);
    for (int a = 1; a < 6; a++)
      rd_cmp(5'(a), 16'h0000);
    rd_cmp(5'h06, 16'(mdl[6]));
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 1; a < 10; a++)
      mdl[a] = 0;
    chk_all(24);
    mdl[6] = $random(seed) & 32'hffff;
    mdl[7] = ($random(seed) & 32'hffff) | 1;
    wr(5'h06, 16'(mdl[6]));
    wr(5'h07, 16'(mdl[7]));
    for (int j = 0; j < 12; j++) begin
      n = (j < 6) ? j : j + 2;
      run({8'ha1, 8'h10 | 8'(n)}, 16'h0000, 16'h8080);
      stop(20);
      if (n < 8)
        mdl[tg[j % 6]] = (mdl[tg[j % 6]] + mdl[7]) & 32'hffff;
      else
        mdl[tg[j % 6]] = mdl[6];
      mdl[9] = 1;
      chk_all(24);
    end
    for (int j = 0; j < 2; j++) begin
      n = ($random(seed) & 32'h3) + 1;
      mdl[4 + j] = n;
      wr(5'(4 + j), 16'(n));
      run({j ? 8'he0 : 8'hc0, 8'h15}, 16'ha30e, 16'h8080);
      stop(60);
      mdl[8] = (mdl[8] + (n + 1) * mdl[7]) & 32'hffff;
      mdl[9] = 3;
      cmp(adc_channel_select, 16'(mdl[8]));
      chk_all(24);
    end
    // j 0: no delay, j 1: step delay n, j 2: timer1 wait with limit n
    for (int j = 0; j < 3; j++) begin
      n = (j == 0) ? 0 : (($random(seed) & 32'h7) + 1);
      wr((j == 2) ? 5'h02 : 5'h03, 16'(n));
      run(16'h0e15, (j == 2) ? 16'ha009 : 16'h00a0, 16'h8080 | 16'(j == 1));
      @(adc_channel_select);
      t0 = $time;
      v = adc_channel_select;
      @(adc_channel_select);
      cmp(16'(($time - t0) / 20), 16'((j == 2) ? 12 + n : 3 * (n + 3)));
      cmp(adc_channel_select - v, 16'(mdl[7]));
      stop(1);
    end
    report_and_stop();
  end
  initial begin
    #400000;
    fails++;
    report_and_stop();
  end
endmodule : tsq_core_tb
`default_nettype wire

// ===== tsq_counter.sv
/*
  16-bit wait counter: counts up from zero while running and holds at the limit, flags match.
  assumes: same clock and reset as the sequencer core.
*/
`default_nettype none
module tsq_counter (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic run,
  input wire tsq_pkg::tsq_word_t limit,
  output logic match,
  output tsq_pkg::tsq_word_t count
);
  tsq_pkg::tsq_word_t count_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= 16'h0000;
    end else if (start) begin
      count_q <= 16'h0000;
    end else if (run && count_q != limit) begin
      count_q <= count_q + 16'h0001;
    end
  end

  assign match = run && (count_q == limit);
  assign count = count_q;
endmodule : tsq_counter
`default_nettype wire

// ===== tsq_map.svh
/*
  register offsets, field positions and reset values of the
  trigger sequencer data register block.
  assumes: included by bare name; word-indexed register port.
*/
`ifndef TSQ_MAP_SVH
`define TSQ_MAP_SVH

`define TSQ_ADDR_W 5
`define TSQ_OFF_CTRL 5'h00
`define TSQ_OFF_TIMER0_LIMIT 5'h01
`define TSQ_OFF_TIMER1_LIMIT 5'h02
`define TSQ_OFF_STEP_DELAY_LIMIT 5'h03
`define TSQ_OFF_LOOP_COUNTER0_LIMIT 5'h04
`define TSQ_OFF_LOOP_COUNTER1_LIMIT 5'h05
`define TSQ_OFF_COPY_SOURCE_VALUE 5'h06
`define TSQ_OFF_ADD_SOURCE_VALUE 5'h07
`define TSQ_OFF_ADC_CHANNEL_LITERAL 5'h08
`define TSQ_OFF_ACTIVE_STEP_POINTER 5'h09
`define TSQ_OFF_ADC_CHANNEL_SELECT 5'h0a
`define TSQ_OFF_QUEUE_BASE 5'h10
`define TSQ_QUEUE_REGS 8
`define TSQ_QUEUE_IDX_W 3

`define TSQ_CTRL_ENABLE_BIT 15
`define TSQ_CTRL_VIS_BIT 8
`define TSQ_CTRL_RUN_BIT 7
`define TSQ_CTRL_DELAY_ON_BIT 0

`define TSQ_RESET_VALUE 16'h0000
`define TSQ_PTR_W 5
`define TSQ_PTR_MASK 16'h001f
`define TSQ_BYTE_W 8

`endif

// ===== tsq_pkg.sv
/*
  types shared by the trigger sequencer data register block.
  assumes: nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package tsq_pkg;
  typedef logic [15:0] tsq_word_t;
  typedef enum logic [1:0] {
    TSQ_FETCH = 2'b00,
    TSQ_EXEC = 2'b01,
    TSQ_WAIT = 2'b11
  } tsq_state_e;
  typedef enum logic [2:0] {
    TSQ_TGT_C0 = 3'h0,
    TSQ_TGT_C1 = 3'h1,
    TSQ_TGT_T0 = 3'h2,
    TSQ_TGT_T1 = 3'h3,
    TSQ_TGT_SD = 3'h4,
    TSQ_TGT_LIT = 3'h5
  } tsq_target_e;
endpackage : tsq_pkg
`default_nettype wire
